// ### rtl/stop_seq_pkg.sv
// Package with constants and carrier types of the contactor stop sequencer
package stop_seq_pkg;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned TICK_US       = 1000;  // Timebase tick in us
  localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TIMEOUT_MS    = 1000;  // One second
  localparam int unsigned TIMEOUT_TICKS = TIMEOUT_MS * 1000 / TICK_US;
  localparam int unsigned TICK_W        = 14;
  localparam int unsigned TMO_W         = 11;

  // --------------------------------------------------------------------------
  // Feedback scaling: 16 bit code, full scale 10 V = 300 percent
  // --------------------------------------------------------------------------
  localparam int unsigned FB_W        = 16;
  localparam int unsigned GAIN_W      = 16;
  localparam int unsigned GAIN_FRAC   = 14;  // Gain 1.0 is 0x4000
  localparam int unsigned FULL_PCT    = 300;
  localparam int unsigned PCT_W       = 10;  // Percent x1, up to 1023
  localparam logic [15:0] GAIN_RST    = 16'h4000;
  localparam logic [FB_W-1:0] FB_FULL = 16'h7FFF;

  // Alarm code reported on the contactor-not-closed alarm
  localparam logic [15:0] ALM_ARM_NOT_CLOSED = 16'h0024;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_ARM_RAMP,
    ST_ARM_CHECK,
    ST_FLD_RAMP,
    ST_LOCKED
  } seq_state_t;

  // Raw digital inputs from terminals
  typedef struct packed {
    logic start;          // Start command level
    logic stop;           // Stop request level
    logic thermostat;     // Closed loop = 1
    logic coast_jumper;   // Closed jumper = 1
    logic interlock;      // Customer interlock closed = 1
    logic arm_closed;     // Armature contactor aux, closed = 1
    logic fld_closed;     // Field main contactor n.o. aux
    logic arm_i_zero;     // Armature current at zero
    logic fld_i_zero;     // Field current at zero
    logic arm_mon_en;     // Armature contactor monitoring enabled
    logic fault_reset;    // Fault and alarm reset
  } seq_in_t;

  typedef struct packed {
    logic arm_ref_zero;   // Force armature current reference to zero
    logic arm_contactor;  // Armature contactor drive
    logic fld_loop_en;    // Field current loop enable
    logic fld_relay;      // Field contactor relay output
    logic ready;          // Start permitted
    logic running;
  } seq_out_t;

  typedef struct packed {
    logic arm_not_closed;  // Alarm, contactor not closed after start
    logic arm_i_not_zero;  // Alarm, current not zero in time
    logic fld_i_not_zero;  // Alarm, field current not zero in time
    logic arm_not_open;    // Fault, blocks restart
  } seq_flags_t;

endpackage : stop_seq_pkg

// ### rtl/arm_fb_scaler.sv
// Armature current feedback gain scaler and percent conversion
module arm_fb_scaler
  import stop_seq_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [FB_W-1:0]   fb_raw_i,
  input  wire logic [GAIN_W-1:0] gain_i,
  output logic      [FB_W-1:0]   fb_scaled_o,
  output logic      [PCT_W-1:0]  fb_pct_o
);

  logic [FB_W+GAIN_W-1:0] prod;
  logic [FB_W+GAIN_W-1:0] shifted;
  logic [FB_W-1:0]        sat_d;
  logic [FB_W+9:0]        pct_prod;

  // Gain multiply, then saturate to full scale
  always_comb begin
    prod    = fb_raw_i * gain_i;
    shifted = prod >> GAIN_FRAC;
    if (shifted > {{GAIN_W{1'b0}}, FB_FULL}) begin
      sat_d = FB_FULL;
    end else begin
      sat_d = shifted[FB_W-1:0];
    end
  end

  // Full scale code is 300 percent of rated current
  assign pct_prod = fb_scaled_o * 10'(FULL_PCT);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fb_scaled_o <= '0;
      fb_pct_o    <= '0;
    end else begin
      fb_scaled_o <= sat_d;
      fb_pct_o    <= PCT_W'(pct_prod / (FB_W+10)'(FB_FULL));
    end
  end

endmodule : arm_fb_scaler

// ### rtl/contactor_stop_sequencer.sv
// Start permission and stop sequencing of the field current regulator
module contactor_stop_sequencer
  import stop_seq_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire seq_in_t           pins_i,
  input  wire logic [FB_W-1:0]   arm_fb_i,
  input  wire logic [GAIN_W-1:0] fb_gain_i,
  output seq_out_t               ctl_o,
  output seq_flags_t             flags_o,
  output logic      [15:0]       alarm_code_o,
  output logic      [FB_W-1:0]   arm_fb_scaled_o,
  output logic      [PCT_W-1:0]  arm_fb_pct_o
);

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  // Release through two flops so all logic leaves reset on one edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  seq_in_t sync1_q;
  seq_in_t in_q;

  // Terminals are asynchronous; first stage is read by the second only
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      in_q    <= '0;
    end else begin
      sync1_q <= pins_i;
      in_q    <= sync1_q;
    end
  end

  logic [FB_W-1:0] fb_s1_q;
  logic [FB_W-1:0] fb_q;

  // Feedback word from the converter, held steady by the converter
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fb_s1_q <= '0;
      fb_q    <= '0;
    end else begin
      fb_s1_q <= arm_fb_i;
      fb_q    <= fb_s1_q;
    end
  end

  // --------------------------------------------------------------------------
  // Timebase
  // --------------------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt_q;
  logic              tick_q;

  // Free running millisecond tick from the system clock
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_W'(TICK_CYC - 1)) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q     <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  seq_state_t       state_q;
  seq_state_t       state_d;
  logic [TMO_W-1:0] tmo_q;
  logic             tmo_done;
  logic             start_ok;
  logic             start_q;
  logic             start_rise;
  logic             stop_req;
  logic             run_tmo_q;  // Start supervision running
  seq_flags_t       flags_q;

  assign tmo_done   = (tmo_q == TMO_W'(TIMEOUT_TICKS));
  assign start_rise = in_q.start && !start_q;

  // Thermostat loop, coast jumper and interlock must all be closed, with no not-open fault, to start
  assign start_ok = in_q.thermostat
                 && in_q.coast_jumper
                 && in_q.interlock
                 && !flags_q.arm_not_open;

  // Interlock opening, stop key or lost permissives start the stop sequence
  assign stop_req = !in_q.interlock
                 || in_q.stop
                 || !in_q.thermostat
                 || !in_q.coast_jumper;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= 1'b0;
    end else begin
      start_q <= in_q.start;
    end
  end

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_rise && start_ok) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_req) begin
          state_d = ST_ARM_RAMP;
        end
      end
      ST_ARM_RAMP: begin
        if (in_q.arm_i_zero || tmo_done) begin
          state_d = ST_ARM_CHECK;
        end
      end
      ST_ARM_CHECK: begin
        if (!in_q.arm_closed) begin
          state_d = ST_FLD_RAMP;
        end else if (tmo_done) begin
          state_d = ST_LOCKED;
        end
      end
      ST_FLD_RAMP: begin
        if (in_q.fld_i_zero || tmo_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_LOCKED: begin
        if (!in_q.arm_closed) begin
          state_d = ST_FLD_RAMP;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Step timer restarts on every state change
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tmo_q <= '0;
    end else if (state_d != state_q || (start_rise && state_q == ST_RUN)) begin
      tmo_q <= '0;
    end else if (tick_q && !tmo_done) begin
      tmo_q <= tmo_q + 1'b1;
    end
  end

  // Contactor closing supervision after start
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      run_tmo_q <= 1'b0;
    end else if (state_q == ST_IDLE && state_d == ST_RUN) begin
      run_tmo_q <= in_q.arm_mon_en;
    end else if (state_q != ST_RUN || in_q.arm_closed || tmo_done) begin
      run_tmo_q <= 1'b0;
    end
  end

  // Sticky flags; the setting event wins over a reset in the same cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else begin
      if (in_q.fault_reset) begin
        flags_q.arm_not_closed <= 1'b0;
        flags_q.arm_i_not_zero <= 1'b0;
        flags_q.fld_i_not_zero <= 1'b0;
        if (state_q != ST_LOCKED) begin
          flags_q.arm_not_open <= 1'b0;
        end
      end
      if (run_tmo_q && tmo_done && !in_q.arm_closed) begin
        flags_q.arm_not_closed <= 1'b1;
      end
      if (state_q == ST_ARM_RAMP && tmo_done && !in_q.arm_i_zero) begin
        flags_q.arm_i_not_zero <= 1'b1;
      end
      if (state_q == ST_FLD_RAMP && tmo_done && !in_q.fld_i_zero) begin
        flags_q.fld_i_not_zero <= 1'b1;
      end
      if (state_d == ST_LOCKED) begin
        flags_q.arm_not_open <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Registered from next state so outputs follow the sequence with no lag
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctl_o <= '0;
    end else begin
      ctl_o.arm_ref_zero  <= (state_d != ST_RUN);
      ctl_o.arm_contactor <= (state_d == ST_RUN)
                          || (state_d == ST_ARM_RAMP);
      ctl_o.fld_loop_en   <= (state_d == ST_RUN) || (state_d == ST_ARM_RAMP)
                          || (state_d == ST_ARM_CHECK)
                          || (state_d == ST_LOCKED);
      ctl_o.fld_relay     <= (state_d != ST_IDLE);
      ctl_o.ready         <= (state_d == ST_IDLE) && start_ok;
      ctl_o.running       <= (state_d == ST_RUN) && in_q.fld_closed;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flags_o      <= '0;
      alarm_code_o <= '0;
    end else begin
      flags_o      <= flags_q;
      alarm_code_o <= flags_q.arm_not_closed ? ALM_ARM_NOT_CLOSED : 16'h0000;
    end
  end

  // Gain correction and scaling of the armature current feedback
  arm_fb_scaler u_scaler (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .fb_raw_i    (fb_q),
    .gain_i      (fb_gain_i),
    .fb_scaled_o (arm_fb_scaled_o),
    .fb_pct_o    (arm_fb_pct_o)
  );

endmodule : contactor_stop_sequencer

// ### verif/stop_seq_monitor.sv
// Port checker of the contactor stop sequencer
module stop_seq_monitor
  import stop_seq_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire seq_in_t           pins_i,
  input wire logic [FB_W-1:0]   arm_fb_i,
  input wire logic [GAIN_W-1:0] fb_gain_i,
  input wire seq_out_t          ctl_o,
  input wire seq_flags_t        flags_o,
  input wire logic [15:0]       alarm_code_o,
  input wire logic [FB_W-1:0]   arm_fb_scaled_o,
  input wire logic [PCT_W-1:0]  arm_fb_pct_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // -------------------------------------------------------------------------
  // Sequences and properties
  // -------------------------------------------------------------------------
  // Reference held at zero and current seen at zero long enough to sync
  sequence s_ramp_done;
    (ctl_o.arm_ref_zero && pins_i.arm_i_zero) [*4];
  endsequence

  property p_thermo;
    !pins_i.thermostat [*4] |-> !ctl_o.ready;
  endproperty
  property p_jumper;
    !pins_i.coast_jumper [*4] |-> !ctl_o.ready;
  endproperty
  property p_ilock;
    $fell(pins_i.interlock) && ctl_o.running |-> ##[1:4] ctl_o.arm_ref_zero;
  endproperty
  property p_release;
    s_ramp_done |-> ##[0:3] !ctl_o.arm_contactor;
  endproperty
  property p_loop_after;
    $fell(ctl_o.fld_loop_en) |-> !ctl_o.arm_contactor;
  endproperty
  property p_relay_last;
    $fell(ctl_o.fld_relay) |-> !ctl_o.fld_loop_en;
  endproperty
  property p_run_relay;
    ctl_o.running |-> ctl_o.fld_relay;
  endproperty
  property p_aux;
    $rose(ctl_o.running) |-> $past(pins_i.fld_closed, 3);
  endproperty
  property p_block;
    flags_o.arm_not_open |-> !ctl_o.ready;
  endproperty
  // Percent output can never pass the 300 percent full scale
  property p_pct;
    arm_fb_pct_o <= 10'h12C;
  endproperty

  a_thermo:     assert property (p_thermo) else $error("ready with thermostat open");
  a_jumper:     assert property (p_jumper) else $error("ready without jumper");
  a_ilock:      assert property (p_ilock) else $error("reference not zeroed");
  a_release:    assert property (p_release) else $error("contactor held");
  a_loop_after: assert property (p_loop_after) else $error("loop off early");
  a_relay_last: assert property (p_relay_last) else $error("relay off early");
  a_run_relay:  assert property (p_run_relay) else $error("run without relay");
  a_aux:        assert property (p_aux) else $error("run without aux");
  a_block:      assert property (p_block) else $error("restart not blocked");
  a_pct:        assert property (p_pct) else $error("percent above scale");
endmodule : stop_seq_monitor

// ### verif/contactor_model.sv
// Behavioural model of the external contactors and power stages
module contactor_model
  import stop_seq_pkg::*;
#(
  parameter int DLY = 3
)(
  input  wire seq_out_t ctl_i,
  input  wire logic     clk_i,
  output logic          arm_closed_o,
  output logic          fld_closed_o,
  output logic          arm_i_zero_o,
  output logic          fld_i_zero_o
);
  logic [DLY-1:0] arm_q = '0;
  logic [DLY-1:0] fld_q = '0;
  logic [DLY-1:0] ai_q  = '0;
  logic [DLY-1:0] fi_q  = '0;
  logic [23:0]    estop_cnt_q = '0;  // Timer relay, one second of clocks

  // Timer relay backstop: once the stop sequence has begun, the field
  // contactor drops one second later even if the relay output sticks
  always_ff @(posedge clk_i) begin
    if (!ctl_i.arm_ref_zero) begin
      estop_cnt_q <= '0;
    end else if (estop_cnt_q != 24'(CLK_HZ)) begin
      estop_cnt_q <= estop_cnt_q + 24'h000001;
    end
  end

  // Delay lines stand in for coil pull-in and current decay times
  always_ff @(posedge clk_i) begin
    arm_q <= {arm_q[DLY-2:0], ctl_i.arm_contactor};
    fld_q <= {fld_q[DLY-2:0], ctl_i.fld_relay};
    ai_q  <= {ai_q[DLY-2:0], ctl_i.arm_contactor && !ctl_i.arm_ref_zero};
    fi_q  <= {fi_q[DLY-2:0], ctl_i.fld_relay && ctl_i.fld_loop_en};
  end

  // Normally open aux contact follows the field main contactor
  assign fld_closed_o = fld_q[DLY-1]
                     && (estop_cnt_q != 24'(CLK_HZ));
  assign arm_closed_o = arm_q[DLY-1];
  assign arm_i_zero_o = !ai_q[DLY-1];
  assign fld_i_zero_o = !fi_q[DLY-1];
endmodule : contactor_model

// ### verif/contactor_stop_sequencer_tb.sv
// Testbench of the contactor stop sequencer
module contactor_stop_sequencer_tb
  import stop_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  seq_in_t           drv_q;
  seq_in_t           pins;
  logic [FB_W-1:0]   fb_q;
  logic [GAIN_W-1:0] gain_q;
  seq_out_t          ctl;
  seq_flags_t        flags;
  logic [15:0]       alarm;
  logic [FB_W-1:0]   scaled;
  logic [PCT_W-1:0]  pct;
  logic              ac, fc, az, fz;
  int                error_cnt = 0;
  int                checks = 0;

  always #50 clk_i = ~clk_i;

  // Feedback contacts come from the partner, the rest from the bench
  always_comb begin
    pins            = drv_q;
    pins.arm_closed = ac;
    pins.fld_closed = fc;
    pins.arm_i_zero = az;
    pins.fld_i_zero = fz;
  end

  contactor_stop_sequencer i_contactor_stop_sequencer (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .pins_i(pins), .arm_fb_i(fb_q),
    .fb_gain_i(gain_q), .ctl_o(ctl), .flags_o(flags),
    .alarm_code_o(alarm), .arm_fb_scaled_o(scaled), .arm_fb_pct_o(pct));

  contactor_model i_contactor_model (
    .ctl_i(ctl), .clk_i(clk_i), .arm_closed_o(ac), .fld_closed_o(fc),
    .arm_i_zero_o(az), .fld_i_zero_o(fz));

  // -------------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // Bounded wait on one output bit; a hang ends the run
  task automatic wait_ctl(input int b, input logic v);
    int n;
    n = 0;
    while (ctl[b] !== v) begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 300) begin
        error_cnt++;
        $display("mismatch at %0t: wait ran out", $time);
        results();
      end
    end
  endtask : wait_ctl

  // -------------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------------
  // Open thermostat, jumper, interlock in turn and try to start
  task automatic t_refuse();
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i);
      drv_q[8-k] <= 1'b0;
      repeat (5) @(posedge clk_i);
      drv_q.start <= 1'b1;
      repeat (5) @(posedge clk_i);
      #1;
      chk(16'(ctl[4:1]), 16'h0000);
      @(posedge clk_i);
      drv_q.start <= 1'b0;
      drv_q[8-k]  <= 1'b1;
      wait_ctl(1, 1'b1);
    end
  endtask : t_refuse

  task automatic t_start();
    @(posedge clk_i);
    drv_q.start <= 1'b1;
    wait_ctl(0, 1'b1);
    chk(16'(ctl[5:2]), 16'h0007);
    @(posedge clk_i);
    drv_q.start <= 1'b0;
  endtask : t_start

  // Bit 9 raises stop, bit 6 opens the interlock
  task automatic t_stop(input int b);
    @(posedge clk_i);
    drv_q[b] <= ~drv_q[b];
    repeat (4) @(posedge clk_i);
    #1;
    chk(16'(ctl[5:4]), 16'h0003);
    wait_ctl(4, 1'b0);
    chk(16'(ctl.fld_loop_en), 16'h0001);
    wait_ctl(2, 1'b0);
    chk(16'(ctl.fld_loop_en), 16'h0000);
    chk(16'(flags), 16'h0000);
    chk(alarm, 16'h0000);
    @(posedge clk_i);
    drv_q[b] <= ~drv_q[b];
    wait_ctl(1, 1'b1);
  endtask : t_stop

  task automatic t_scale(input logic [15:0] f, input logic [15:0] g,
                         input logic [15:0] es, input logic [15:0] ep);
    @(posedge clk_i);
    fb_q   <= f;
    gain_q <= g;
    repeat (6) @(posedge clk_i);
    #1;
    chk(scaled, es);
    chk(16'(pct), ep);
  endtask : t_scale

  // Reset held ten cycles, monitoring on, permissives closed
  initial begin
    drv_q  = 11'h1C2;
    fb_q   = 16'h0000;
    gain_q = 16'h4000;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wait_ctl(1, 1'b1);
    t_refuse();
    t_start();
    t_stop(9);
    t_start();
    t_stop(6);
    t_scale(16'h7FFF, 16'h4000, 16'h7FFF, 16'h012C);
    t_scale(16'h7FFF, 16'h2000, 16'h3FFF, 16'h0095);
    t_scale(16'h7FFF, 16'h8000, 16'h7FFF, 16'h012C);
    t_scale(16'h4000, 16'h4000, 16'h4000, 16'h0096);
    results();
  end
endmodule : contactor_stop_sequencer_tb

bind contactor_stop_sequencer stop_seq_monitor i_stop_seq_monitor (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .pins_i(pins_i), .arm_fb_i(arm_fb_i),
  .fb_gain_i(fb_gain_i), .ctl_o(ctl_o), .flags_o(flags_o),
  .alarm_code_o(alarm_code_o), .arm_fb_scaled_o(arm_fb_scaled_o),
  .arm_fb_pct_o(arm_fb_pct_o));
